// *** pmo_pkg.sv ***
// Package of constants and carrier types for the pulse margining outputs.
package pmo_pkg;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int FAST_DIV_W = 14;
  localparam int SLOW_DIV_W = 24;
  localparam int FAST_SUB = 16;
  localparam int N_FAST = 8;
  localparam int N_SLOW = 2;
  localparam int N_RAIL = 10;
  localparam int N_SPIN = 4;
  localparam logic [13:0] FAST_DIV_RST = 14'h0002;
  localparam logic [23:0] SLOW_DIV_RST = 24'h000002;
  localparam logic [31:0] MS_PER_DAY = 32'h05265c00;
  localparam real CLK_MHZ = 20.0;
  localparam real MS_TIME = 1.0;
  localparam int MS_CYCLES = int'(MS_TIME * 1000.0 * CLK_MHZ);

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] REG_FAST_DIV = 8'h00;
  localparam logic [7:0] REG_FAST_DUTY = 8'h04;
  localparam logic [7:0] REG_FAST_PHASE = 8'h0c;
  localparam logic [7:0] REG_SLOW_DIV = 8'h14;
  localparam logic [7:0] REG_SLOW_DUTY = 8'h16;
  localparam logic [7:0] REG_PIN_CFG = 8'h18;
  localparam logic [7:0] REG_SPIN_CFG = 8'h19;
  localparam logic [7:0] REG_RAIL_CFG = 8'h1a;
  localparam logic [7:0] REG_TARGET = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h2e;
  localparam logic [7:0] REG_CLR = 8'h2f;
  localparam logic [7:0] REG_RT_MS = 8'h30;
  localparam logic [7:0] REG_RT_DAY = 8'h31;
  localparam logic [7:0] REG_STORE = 8'h32;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int PIN_GPO_EN = 0;
  localparam int PIN_PULSE_EN = 8;
  localparam int PIN_GPO_VAL = 16;
  localparam int SP_POL = 0;
  localparam int SP_FAULT_EN = 4;
  localparam int SP_SEL_LO = 8;
  localparam int SP_SEL_HI = 12;
  localparam int RC_MODE_LO = 0;
  localparam int RC_UP_DIR = 2;
  localparam int RC_MRG_EN = 3;
  localparam int RC_OPEN_LOOP = 4;
  localparam int RC_OUT_LO = 8;
  localparam int RC_FIX_LO = 16;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    PMO_MRG_OFF = 2'h0,
    PMO_MRG_TRI = 2'h1,
    PMO_MRG_TRIM = 2'h2,
    PMO_MRG_FIXED = 2'h3
  } pmo_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pmo_bus_req_t;

  typedef struct packed {
    logic [N_FAST-1:0] o;
    logic [N_FAST-1:0] oe_n;
  } pmo_pin_t;

endpackage

// *** pmo_rc_model.sv ***
// Far-side model of the filter network and supply feedback for one margined rail.
module pmo_rc_model (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic pulse_in,
  output logic [11:0] meas_out
);
  // The filtered level creeps up while the pulse is high and down while it is low.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meas_out <= 12'h000;
    end else if (pulse_in === 1'b1 && meas_out != 12'hfff) begin
      meas_out <= meas_out + 12'h001;
    end else if (pulse_in !== 1'b1 && meas_out != 12'h000) begin
      meas_out <= meas_out - 12'h001;
    end
  end
endmodule // pmo_rc_model

// *** pmo_top.sv ***
// Pulse margining output generator with register port and run-time clock.
//
// Functional notes
// - Fast outputs divide the source clock by an integer two to 2^14-1.
// - Fast outputs 1-2, 3-4, 5-6, 7-8 share one divisor each.
// - Fast duty step is one sixteenth of a source clock period.
// - Slow outputs divide their clock by integer two to 2^24-1.
// - Slow duty step is one slow source clock period.
// - Below 238 Hz the duty counter width caps resolution.
// - Each fast output has its own phase offset up to a full period.
// - A fast pin not pulsing may act as a general output.
// - Fast pins used as general outputs drive low from reset.
// - Pulsing one pair pin also pulses an unassigned companion.
// - Margin enable puts every margining rail into its margined state.
// - Margin direction asserted selects low, deasserted selects high.
// - Each special input has a configurable active polarity.
// - With fault enable set, a deasserted input raises a fault.
// - The clear-source input clears latched rail status flags.
// - Rail-state selector uses the first three special inputs.
// - Closed loop steps duty from measured voltage toward the target.
// - Duty-to-voltage direction is configurable per rail.
// - Four modes: off, idle tri-state, idle trim, idle fixed duty.
// - Open loop drives two open-drain pins per rail.
// - Run-time clock holds 32-bit milliseconds and days, stored on request.
//
// Chosen here: the address map and the strobed register port.
module pmo_top #(
  parameter int MS_CNT = pmo_pkg::MS_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [pmo_pkg::N_SPIN-1:0] special_input_pin_in,
  input wire logic [pmo_pkg::N_RAIL*12-1:0] rail_meas_in,
  input wire logic [pmo_pkg::N_RAIL-1:0] rail_status_in,
  input wire logic power_down_in,
  output logic [31:0] rdata_out,
  output logic [pmo_pkg::N_FAST-1:0] fast_pulse_out,
  output logic [pmo_pkg::N_FAST-1:0] fast_pulse_oe_n_out,
  output logic slow_pulse_out_a,
  output logic slow_pulse_out_b,
  output logic [pmo_pkg::N_SLOW-1:0] slow_pulse_oe_n_out,
  output logic [pmo_pkg::N_RAIL*2-1:0] open_loop_oe_n_out,
  output logic [pmo_pkg::N_RAIL-1:0] rail_latched_out,
  output logic [2:0] rail_state_sel_out,
  output logic input_fault_out,
  output logic store_req_out,
  output logic [63:0] store_data_out
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [3:0][13:0] fdiv, fdiv_act;
    logic [7:0][17:0] fduty, fduty_act;
    logic [7:0][17:0] fphase;
    logic [3:0][17:0] fcnt;
    logic [1:0][23:0] sdiv, sdiv_act, sduty, sduty_act, scnt;
    logic [23:0] pin_cfg;
    logic [15:0] spin_cfg;
    logic [9:0][23:0] rail_cfg;
    logic [9:0][23:0] target;
    logic [9:0][15:0] trim_duty;
    logic [9:0] latched;
    logic [7:0] fout;
    logic [1:0] sout;
    logic [31:0] rt_ms, rt_day, ms_cnt;
    logic store;
    logic [31:0] rdata;
  } pmo_state_t;

  pmo_state_t st_ff, nxt_st;
  pmo_pkg::pmo_bus_req_t req;
  logic [3:0] sp_act;
  logic mrg_en, mrg_low;
  logic [7:0] pmask;

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  assign pmask = pulse_mask(st_ff.pin_cfg);

  function automatic logic [7:0] pulse_mask(input logic [23:0] cfg);
    logic [7:0] m;
    m = cfg[pmo_pkg::PIN_PULSE_EN +: 8];
    for (int p = 0; p < 8; p++) begin
      if (m[p ^ 1] && !cfg[pmo_pkg::PIN_GPO_EN + p]) begin
        m[p] = 1'b1;
      end
    end
    return m;
  endfunction

  // ==========================================================================
  // Special inputs
  // ==========================================================================
  always_comb begin
    sp_act = special_input_pin_in ^ ~st_ff.spin_cfg[pmo_pkg::SP_POL +: 4];
    mrg_en = sp_act[2];
    mrg_low = sp_act[3];
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    logic [7:0] pm;
    logic [17:0] per;
    logic [11:0] meas;
    logic [11:0] tgt;
    logic up, want_up;
    logic [15:0] d;
    logic [7:0][17:0] eff;
    nxt_st = st_ff;
    pm = pulse_mask(st_ff.pin_cfg);
    per = '0;
    meas = '0;
    tgt = '0;
    up = 1'b0;
    want_up = 1'b0;
    d = '0;
    eff = st_ff.fduty;
    nxt_st.store = 1'b0;
    // Margined pins take their duty from the owning rail.
    for (int r = 0; r < 10; r++) begin
      if (st_ff.rail_cfg[r][pmo_pkg::RC_MODE_LO +: 2] != 2'(pmo_pkg::PMO_MRG_OFF)) begin
        for (int p = 0; p < 8; p++) begin
          if (st_ff.rail_cfg[r][pmo_pkg::RC_OUT_LO +: 4] == 4'(p)) begin
            if ((mrg_en && st_ff.rail_cfg[r][pmo_pkg::RC_MRG_EN])
                || st_ff.rail_cfg[r][pmo_pkg::RC_MODE_LO +: 2] == 2'(pmo_pkg::PMO_MRG_TRIM)) begin
              eff[p] = {2'b00, st_ff.trim_duty[r]};
            end else if (st_ff.rail_cfg[r][pmo_pkg::RC_MODE_LO +: 2] == 2'(pmo_pkg::PMO_MRG_FIXED)) begin
              eff[p] = {10'h000, st_ff.rail_cfg[r][pmo_pkg::RC_FIX_LO +: 8]};
            end
          end
        end
      end
    end
    // Fast pairs count in sixteenths of a source period.
    for (int k = 0; k < 4; k++) begin
      per = {st_ff.fdiv_act[k], 4'h0};
      if (st_ff.fcnt[k] >= per - 18'h00001) begin
        nxt_st.fcnt[k] = '0;
        nxt_st.fdiv_act[k] = st_ff.fdiv[k];
        nxt_st.fduty_act[2*k] = eff[2*k];
        nxt_st.fduty_act[2*k+1] = eff[2*k+1];
      end else begin
        nxt_st.fcnt[k] = st_ff.fcnt[k] + 18'h00001;
      end
      for (int j = 0; j < 2; j++) begin
        logic [18:0] ph;
        ph = {1'b0, st_ff.fcnt[k]} + {1'b0, st_ff.fphase[2*k+j]};
        if (ph >= {1'b0, per}) begin
          ph = ph - {1'b0, per};
        end
        nxt_st.fout[2*k+j] = (ph[17:0] < st_ff.fduty_act[2*k+j]);
      end
    end
    for (int s = 0; s < 2; s++) begin
      if (st_ff.scnt[s] >= st_ff.sdiv_act[s] - 24'h000001) begin
        nxt_st.scnt[s] = '0;
        nxt_st.sdiv_act[s] = st_ff.sdiv[s];
        nxt_st.sduty_act[s] = st_ff.sduty[s];
      end else begin
        nxt_st.scnt[s] = st_ff.scnt[s] + 24'h000001;
      end
      nxt_st.sout[s] = (st_ff.scnt[s] < st_ff.sduty_act[s]);
    end
    // Closed-loop trim steps once per millisecond tick.
    for (int r = 0; r < 10; r++) begin
      meas = rail_meas_in[r*12 +: 12];
      up = st_ff.rail_cfg[r][pmo_pkg::RC_UP_DIR];
      if (mrg_en && st_ff.rail_cfg[r][pmo_pkg::RC_MRG_EN]) begin
        tgt = mrg_low ? st_ff.target[r][11:0] : st_ff.target[r][23:12];
      end else begin
        tgt = st_ff.target[r][11:0];
      end
      d = st_ff.trim_duty[r];
      want_up = (meas < tgt) ~^ up;
      if (st_ff.ms_cnt == 32'h0 && meas != tgt
          && st_ff.rail_cfg[r][pmo_pkg::RC_MODE_LO +: 2] != 2'(pmo_pkg::PMO_MRG_OFF)) begin
        if (want_up && d != 16'hffff) begin
          d = d + 16'h0001;
        end else if (!want_up && d != 16'h0000) begin
          d = d - 16'h0001;
        end
      end
      nxt_st.trim_duty[r] = d;
    end
    // Latched status.
    if (sp_act[1]) begin
      // A new status event in the clearing cycle still latches.
      nxt_st.latched = rail_status_in;
    end else begin
      nxt_st.latched = st_ff.latched | rail_status_in;
    end
    // Run-time clock.
    if (st_ff.ms_cnt >= 32'(MS_CNT - 1)) begin
      nxt_st.ms_cnt = '0;
      if (st_ff.rt_ms == pmo_pkg::MS_PER_DAY - 32'h1) begin
        nxt_st.rt_ms = '0;
        nxt_st.rt_day = st_ff.rt_day + 32'h1;
      end else begin
        nxt_st.rt_ms = st_ff.rt_ms + 32'h1;
      end
    end else begin
      nxt_st.ms_cnt = st_ff.ms_cnt + 32'h1;
    end
    if (power_down_in) begin
      nxt_st.store = 1'b1;
    end
    // Register writes.
    if (req.wr) begin
      for (int k = 0; k < 4; k++) begin
        if (req.addr == pmo_pkg::REG_FAST_DIV + 8'(k) && req.wdata[13:0] >= 14'h0002) begin
          nxt_st.fdiv[k] = req.wdata[13:0];
        end
      end
      for (int p = 0; p < 8; p++) begin
        if (req.addr == pmo_pkg::REG_FAST_DUTY + 8'(p)) begin
          nxt_st.fduty[p] = req.wdata[17:0];
        end
        if (req.addr == pmo_pkg::REG_FAST_PHASE + 8'(p)) begin
          nxt_st.fphase[p] = req.wdata[17:0];
        end
      end
      for (int s = 0; s < 2; s++) begin
        if (req.addr == pmo_pkg::REG_SLOW_DIV + 8'(s) && req.wdata[23:0] >= 24'h000002) begin
          nxt_st.sdiv[s] = req.wdata[23:0];
        end
        if (req.addr == pmo_pkg::REG_SLOW_DUTY + 8'(s)) begin
          nxt_st.sduty[s] = req.wdata[23:0];
        end
      end
      for (int r = 0; r < 10; r++) begin
        if (req.addr == pmo_pkg::REG_RAIL_CFG + 8'(r)) begin
          nxt_st.rail_cfg[r] = req.wdata[23:0];
        end
        if (req.addr == pmo_pkg::REG_TARGET + 8'(r)) begin
          nxt_st.target[r] = req.wdata[23:0];
        end
      end
      case (req.addr)
        pmo_pkg::REG_PIN_CFG: nxt_st.pin_cfg = req.wdata[23:0];
        pmo_pkg::REG_SPIN_CFG: nxt_st.spin_cfg = req.wdata[15:0];
        pmo_pkg::REG_CLR: nxt_st.latched = nxt_st.latched & ~req.wdata[9:0] | rail_status_in;
        pmo_pkg::REG_RT_MS: nxt_st.rt_ms = req.wdata;
        pmo_pkg::REG_RT_DAY: nxt_st.rt_day = req.wdata;
        pmo_pkg::REG_STORE: nxt_st.store = 1'b1;
        default: ;
      endcase
    end
    // Register reads.
    nxt_st.rdata = '0;
    if (req.rd) begin
      case (req.addr)
        pmo_pkg::REG_PIN_CFG: nxt_st.rdata = {8'h00, st_ff.pin_cfg};
        pmo_pkg::REG_SPIN_CFG: nxt_st.rdata = {16'h0000, st_ff.spin_cfg};
        pmo_pkg::REG_STATUS: nxt_st.rdata = {12'h000, sp_act, pm, st_ff.sout, st_ff.fout[5:0]};
        pmo_pkg::REG_CLR: nxt_st.rdata = {22'h000000, st_ff.latched};
        pmo_pkg::REG_RT_MS: nxt_st.rdata = st_ff.rt_ms;
        pmo_pkg::REG_RT_DAY: nxt_st.rdata = st_ff.rt_day;
        default: begin
          for (int k = 0; k < 4; k++) begin
            if (req.addr == pmo_pkg::REG_FAST_DIV + 8'(k)) nxt_st.rdata = {18'h00000, st_ff.fdiv[k]};
          end
          for (int p = 0; p < 8; p++) begin
            if (req.addr == pmo_pkg::REG_FAST_DUTY + 8'(p)) nxt_st.rdata = {14'h0000, st_ff.fduty[p]};
            if (req.addr == pmo_pkg::REG_FAST_PHASE + 8'(p)) nxt_st.rdata = {14'h0000, st_ff.fphase[p]};
          end
          for (int s = 0; s < 2; s++) begin
            if (req.addr == pmo_pkg::REG_SLOW_DIV + 8'(s)) nxt_st.rdata = {8'h00, st_ff.sdiv[s]};
            if (req.addr == pmo_pkg::REG_SLOW_DUTY + 8'(s)) nxt_st.rdata = {8'h00, st_ff.sduty[s]};
          end
          for (int r = 0; r < 10; r++) begin
            if (req.addr == pmo_pkg::REG_RAIL_CFG + 8'(r)) nxt_st.rdata = {8'h00, st_ff.rail_cfg[r]};
            if (req.addr == pmo_pkg::REG_TARGET + 8'(r)) nxt_st.rdata = {16'h0000, st_ff.trim_duty[r]};
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '0;
      for (int k = 0; k < 4; k++) begin
        st_ff.fdiv[k] <= pmo_pkg::FAST_DIV_RST;
        st_ff.fdiv_act[k] <= pmo_pkg::FAST_DIV_RST;
      end
      for (int s = 0; s < 2; s++) begin
        st_ff.sdiv[s] <= pmo_pkg::SLOW_DIV_RST;
        st_ff.sdiv_act[s] <= pmo_pkg::SLOW_DIV_RST;
      end
    end else if (clk_en_in) begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  always_comb begin
    logic [7:0] pm;
    pm = pulse_mask(st_ff.pin_cfg);
    for (int p = 0; p < 8; p++) begin
      if (pm[p]) begin
        fast_pulse_out[p] = st_ff.fout[p];
      end else begin
        fast_pulse_out[p] = st_ff.pin_cfg[pmo_pkg::PIN_GPO_VAL + p];
      end
      fast_pulse_oe_n_out[p] = 1'b0;
    end
    slow_pulse_out_a = st_ff.sout[0];
    slow_pulse_out_b = st_ff.sout[1];
    slow_pulse_oe_n_out = 2'b00;
    for (int r = 0; r < 10; r++) begin
      logic act;
      act = mrg_en && st_ff.rail_cfg[r][pmo_pkg::RC_MRG_EN] && st_ff.rail_cfg[r][pmo_pkg::RC_OPEN_LOOP];
      open_loop_oe_n_out[2*r] = !(act && mrg_low);
      open_loop_oe_n_out[2*r+1] = !(act && !mrg_low);
      if (st_ff.rail_cfg[r][pmo_pkg::RC_MODE_LO +: 2] != 2'(pmo_pkg::PMO_MRG_OFF)) begin
        for (int p = 0; p < 8; p++) begin
          if (st_ff.rail_cfg[r][pmo_pkg::RC_OUT_LO +: 4] == 4'(p)) fast_pulse_out[p] = st_ff.fout[p];
        end
      end
      if (st_ff.rail_cfg[r][pmo_pkg::RC_MODE_LO +: 2] == 2'(pmo_pkg::PMO_MRG_TRI) && !mrg_en) begin
        for (int p = 0; p < 8; p++) begin
          if (st_ff.rail_cfg[r][pmo_pkg::RC_OUT_LO +: 4] == 4'(p)) fast_pulse_oe_n_out[p] = 1'b1;
        end
      end
    end
  end

  assign rail_latched_out = st_ff.latched;
  assign rail_state_sel_out = sp_act[2:0];
  assign input_fault_out = |(~sp_act & st_ff.spin_cfg[pmo_pkg::SP_FAULT_EN +: 4]);
  assign store_req_out = st_ff.store;
  assign store_data_out = {st_ff.rt_day, st_ff.rt_ms};
  assign rdata_out = st_ff.rdata;

  // ==========================================================================
  // Checks
  // ==========================================================================
  chk_div_min_two: assert property (@(posedge sys_clk_in) disable iff (rst_in) st_ff.fdiv[0] >= 14'h0002)
    else $error("fast divisor below two");
  chk_slow_div_min: assert property (@(posedge sys_clk_in) disable iff (rst_in) st_ff.sdiv[1] >= 24'h000002)
    else $error("slow divisor below two");
  chk_div_boundary: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    clk_en_in && st_ff.fcnt[0] != 18'h0 |-> $stable(st_ff.fdiv_act[0]))
    else $error("divisor changed mid period");
  chk_clear_latch: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    clk_en_in && sp_act[1] |=> (st_ff.latched & ~$past(rail_status_in)) == 10'h000)
    else $error("latched status not cleared");
  chk_fault_flag: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st_ff.spin_cfg[4] && !sp_act[0] |-> input_fault_out)
    else $error("fault not raised");
  chk_store_req: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    clk_en_in && power_down_in |=> store_req_out)
    else $error("store not requested");
  chk_gpo_low: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !pmask[0] && st_ff.rail_cfg == '0 && !st_ff.pin_cfg[16] |-> !fast_pulse_out[0])
    else $error("general output not low");
  chk_companion_on: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st_ff.pin_cfg[8] && !st_ff.pin_cfg[1] |-> fast_pulse_out[1] == st_ff.fout[1])
    else $error("companion not pulsing");
  chk_rail_sel: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    rail_state_sel_out == sp_act[2:0])
    else $error("rail selector mismatch");

endmodule // pmo_top

// *** pmo_top_tb.sv ***
// Self-checking testbench for the pulse margining outputs.
module pmo_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Signals, design and partner
  // ==========================================================================
  logic sys_clk_in, rst_in, clk_en_in, wr_in, rd_in, power_down_in, spa, spb, fault, store_req;
  logic [7:0] addr_in, fpo, fpo_oe_n;
  logic [31:0] wdata_in, rdata_out;
  logic [3:0] spin;
  logic [9:0] rail_status, latched;
  logic [11:0] meas0;
  logic [1:0] sp_oe_n;
  logic [19:0] ol_oe_n;
  logic [2:0] sel;
  logic [63:0] store_data;
  logic [8:0] pins;
  int error_cnt, cmp_count;
  // Rows: spin cfg, raw pins, expected selector, fault, open-loop enables [3:2].
  logic [17:0] rows [7] = '{{8'h1f, 4'h5, 3'h5, 1'h0, 2'h1}, {8'h10, 4'h5, 3'h2, 1'h1, 2'h3},
    {8'h15, 4'h0, 3'h2, 1'h1, 2'h3}, {8'h0f, 4'h2, 3'h2, 1'h0, 2'h3}, {8'h1e, 4'h7, 3'h6, 1'h1, 2'h1},
    {8'h0f, 4'hc, 3'h4, 1'h0, 2'h2}, {8'h07, 4'h8, 3'h0, 1'h0, 2'h3}};
  assign pins = {spa, fpo};
  pmo_top #(.MS_CNT(10)) uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .special_input_pin_in(spin),
    .rail_meas_in({{9{12'h800}}, meas0}), .rail_status_in(rail_status), .power_down_in(power_down_in),
    .rdata_out(rdata_out), .fast_pulse_out(fpo), .fast_pulse_oe_n_out(fpo_oe_n), .slow_pulse_out_a(spa),
    .slow_pulse_out_b(spb), .slow_pulse_oe_n_out(sp_oe_n), .open_loop_oe_n_out(ol_oe_n),
    .rail_latched_out(latched), .rail_state_sel_out(sel), .input_fault_out(fault),
    .store_req_out(store_req), .store_data_out(store_data));
  pmo_rc_model rc (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .pulse_in(fpo[4]), .meas_out(meas0));
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    @(negedge sys_clk_in);
    d = rdata_out;
  endtask
  task automatic measure(input int idx, output int hi, output int per);
    int n;
    n = 0;
    hi = 0;
    per = 0;
    while (pins[idx] !== 1'b0 && n < 5000) begin @(negedge sys_clk_in); n++; end
    while (pins[idx] !== 1'b1 && n < 5000) begin @(negedge sys_clk_in); n++; end
    while (pins[idx] === 1'b1 && n < 5000) begin @(negedge sys_clk_in); n++; hi++; per++; end
    while (pins[idx] !== 1'b1 && n < 5000) begin @(negedge sys_clk_in); n++; per++; end
  endtask
  task automatic wait_store(output logic ok);
    int n;
    n = 0;
    while (store_req !== 1'b1 && n < 50) begin @(negedge sys_clk_in); n++; end
    ok = (n < 50);
  endtask
  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================================================
  // Clock, watchdog and sequence
  // ==========================================================================
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    error_cnt++;
    conclude();
  end
  initial begin
    logic [31:0] d1, d2;
    logic [7:0] cfg;
    logic [3:0] pv;
    logic [2:0] es;
    logic ef, ok;
    logic [1:0] eo;
    int hi, per, gap;
    {rst_in, clk_en_in, wr_in, rd_in, power_down_in} = 5'h18;
    {addr_in, wdata_in, spin, rail_status} = '0;
    @(negedge sys_clk_in);
    @(negedge sys_clk_in);
    check("pins in reset", {fpo, fpo_oe_n, sp_oe_n, spb, ol_oe_n}, 64'hfffff);
    @(posedge sys_clk_in) rst_in <= 1'b0;
    rd(pmo_pkg::REG_FAST_DIV + 8'h01, d1);
    check("divisor reset", d1, 64'h2);
    wr(pmo_pkg::REG_RAIL_CFG + 8'h01, 32'h00000018);
    foreach (rows[i]) begin
      {cfg, pv, es, ef, eo} = rows[i];
      wr(pmo_pkg::REG_SPIN_CFG, {24'h0, cfg});
      @(posedge sys_clk_in) spin <= pv;
      repeat (3) @(negedge sys_clk_in);
      check("rail state select", sel, es);
      check("input fault", fault, ef);
      check("open loop pins", ol_oe_n[3:2], eo);
    end
    wr(pmo_pkg::REG_SPIN_CFG, 32'h0000000f);
    @(posedge sys_clk_in) rail_status <= 10'h201;
    repeat (3) @(posedge sys_clk_in);
    rail_status <= 10'h000;
    repeat (3) @(negedge sys_clk_in);
    check("latched held", latched, 10'h201);
    @(posedge sys_clk_in) spin <= 4'h2;
    repeat (3) @(posedge sys_clk_in);
    spin <= 4'h0;
    repeat (3) @(negedge sys_clk_in);
    check("latched cleared", latched, 10'h000);
    wr(pmo_pkg::REG_FAST_DIV, 32'h3);
    wr(pmo_pkg::REG_FAST_DIV, 32'h1);
    rd(pmo_pkg::REG_FAST_DIV, d1);
    check("divisor refusal", d1, 64'h3);
    rd(8'hff, d1);
    check("unmapped read", d1, 64'h0);
    wr(pmo_pkg::REG_FAST_DUTY, 32'd24);
    wr(pmo_pkg::REG_FAST_DUTY + 8'h01, 32'd8);
    wr(pmo_pkg::REG_FAST_PHASE + 8'h01, 32'd12);
    wr(pmo_pkg::REG_PIN_CFG, 32'h0004010c);
    repeat (200) @(negedge sys_clk_in);
    check("general out", {fpo[3:2], fpo_oe_n[3:2]}, 64'h4);
    measure(0, hi, per);
    check("fast high time", hi, 64'd24);
    check("fast period", per, 64'd48);
    measure(1, hi, per);
    check("companion period", {hi, per}, {32'd8, 32'd48});
    while (fpo[0] !== 1'b0) @(negedge sys_clk_in);
    while (fpo[1] !== 1'b0) @(negedge sys_clk_in);
    gap = 0;
    while (fpo[0] !== 1'b1 && gap < 100) begin @(negedge sys_clk_in); gap++; end
    gap = 0;
    while (fpo[1] !== 1'b1 && gap < 100) begin @(negedge sys_clk_in); gap++; end
    check("phase offset", (gap == 12 || gap == 36), 64'h1);
    wr(pmo_pkg::REG_SLOW_DIV, 32'd5);
    wr(pmo_pkg::REG_SLOW_DUTY, 32'd2);
    repeat (20) @(negedge sys_clk_in);
    measure(8, hi, per);
    check("slow pulse", {hi, per}, {32'd2, 32'd5});
    wr(pmo_pkg::REG_FAST_DIV + 8'h02, 32'd4);
    wr(pmo_pkg::REG_TARGET, 32'h00e00100);
    wr(pmo_pkg::REG_RAIL_CFG, 32'h0000040e);
    @(posedge sys_clk_in) spin <= 4'h4;
    rd(pmo_pkg::REG_TARGET, d1);
    repeat (200) @(posedge sys_clk_in);
    rd(pmo_pkg::REG_TARGET, d2);
    check("trim rises", d2 > d1, 64'h1);
    wr(pmo_pkg::REG_RAIL_CFG, 32'h0000040d);
    @(posedge sys_clk_in) spin <= 4'h0;
    repeat (200) @(negedge sys_clk_in);
    check("idle tri-state", fpo_oe_n[4], 64'h1);
    wr(pmo_pkg::REG_RAIL_CFG, 32'h0000040c);
    rd(pmo_pkg::REG_TARGET, d1);
    repeat (100) @(posedge sys_clk_in);
    rd(pmo_pkg::REG_TARGET, d2);
    check("off freezes trim", d2, d1);
    wr(pmo_pkg::REG_RAIL_CFG, 32'h0010040f);
    repeat (300) @(negedge sys_clk_in);
    measure(4, hi, per);
    check("fixed duty", {hi, per}, {32'd16, 32'd64});
    wr(pmo_pkg::REG_RT_DAY, 32'd5);
    wr(pmo_pkg::REG_RT_MS, pmo_pkg::MS_PER_DAY - 32'h1);
    repeat (25) @(posedge sys_clk_in);
    wr(pmo_pkg::REG_STORE, 32'h1);
    wait_store(ok);
    check("store on command", ok, 64'h1);
    check("day rollover", store_data[63:32], 64'd6);
    check("ms after rollover", store_data[31:0] < 4, 64'h1);
    @(posedge sys_clk_in) power_down_in <= 1'b1;
    wait_store(ok);
    check("store on power down", ok, 64'h1);
    @(posedge sys_clk_in) rst_in <= 1'b1;
    power_down_in <= 1'b0;
    @(negedge sys_clk_in);
    check("pins in second reset", {fpo, fpo_oe_n}, 64'h0);
    @(posedge sys_clk_in) rst_in <= 1'b0;
    rd(pmo_pkg::REG_FAST_DIV, d1);
    check("divisor after reset", d1, 64'h2);
    @(posedge sys_clk_in) clk_en_in <= 1'b0;
    @(negedge sys_clk_in);
    d1 = store_data[31:0];
    repeat (30) @(negedge sys_clk_in);
    check("frozen clock", store_data[31:0], d1);
    @(posedge sys_clk_in) clk_en_in <= 1'b1;
    repeat (30) @(negedge sys_clk_in);
    check("clock runs again", store_data[31:0] != d1, 64'h1);
    conclude();
  end
endmodule // pmo_top_tb
